// ===== hw/cond_bits_consts.vh
/*
  Shared constants of the condition-bit block: register offsets and field
  positions on the AXI4-Lite map, reset values, condition-vector bit
  positions and start-cause channel numbers.
  Assumes it is included by bare name into modules that need the values.
*/
`ifndef COND_BITS_CONSTS_VH
`define COND_BITS_CONSTS_VH

// ---------------------------------------------------------------
// register map (byte offsets, one aligned 32-bit word each)
// ---------------------------------------------------------------
`define OFS_CONFIG        8'h00
`define OFS_IRQ_STATUS    8'h04
`define OFS_IRQ_MASK      8'h08
`define OFS_COND_LOW      8'h0C
`define OFS_COND_HIGH     8'h10
`define OFS_OUT_BITS      8'h14

// ---------------------------------------------------------------
// configuration register fields and reset value
// ---------------------------------------------------------------
`define CFG_MODE_SEL_N    0
`define CFG_START_ON_TEMP 1
`define CFG_DUMMY_DCHG    2
`define CFG_COMP_FORCE_N  3
`define CFG_WIDTH         4
`define CFG_RESET         4'h1

// ---------------------------------------------------------------
// start-cause channels (index into the trigger latch)
// ---------------------------------------------------------------
`define NUM_CAUSES        7
`define CH_CAP_DONE       0
`define CH_TIMER          1
`define CH_RES_DONE       2
`define CH_IRQ_EDGE       3
`define CH_CONV_OVF       4
`define CH_GPIO           5
`define CH_SERIAL         6

// ---------------------------------------------------------------
// condition vector positions
// ---------------------------------------------------------------
`define CV_OUT_LSB        56
`define CV_SERIAL_N       55
`define CV_GPIO_N         53
`define CV_CONV_OVF_N     52
`define CV_IRQ_EDGE_N     51
`define CV_RES_DONE_N     50
`define CV_TIMER_N        49
`define CV_CAP_DONE_N     48
`define CV_NO_OVERFLOW    47
`define CV_OVERFLOW       46
`define CV_NO_CARRY       45
`define CV_CARRY          44
`define CV_EQUAL          43
`define CV_NOT_EQUAL      42
`define CV_POSITIVE       41
`define CV_TIMER_RUN      25
`define CV_DUMMY_DCHG     19
`define CV_MODE_SEL_N     18
`define CV_COMP_FORCE_N   17

// ---------------------------------------------------------------
// output bits: which are one-cycle pulses, reset value
// ---------------------------------------------------------------
`define OUT_PULSE_MASK    16'hFF00
`define OUT_RESET         16'h0000

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== hw/sync2.v
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bit is related to another.
*/
`timescale 1ns/1ps

module sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  // asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1Reg;

  // first stage is read only by the second stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1Reg <= {WIDTH{1'b0}};
      syncOut   <= {WIDTH{1'b0}};
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule // sync2

// ===== hw/start_cause_latch.v
/*
  Start-cause latch: per channel a rising-edge detector and an active-low
  flag that drops on the edge and is restored by a stop command.
  Assumes all sources are levels already on clk.
*/
`timescale 1ns/1ps

module start_cause_latch #(
  parameter WIDTH = 7,
  // idle level per source, so leaving reset fakes no edge
  parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  // sources, per-channel enables, stop command
  input  wire [WIDTH-1:0] srcLevel,
  input  wire [WIDTH-1:0] chanEnable,
  input  wire             stopCmd,
  // latched causes (low = caused a start) and edge pulses
  output reg  [WIDTH-1:0] causeFlagN,
  output wire [WIDTH-1:0] edgePulse
);

  reg [WIDTH-1:0] prevReg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gChan
      assign edgePulse[i] = srcLevel[i] & ~prevReg[i] & chanEnable[i];
      // edge beats stop in the same cycle so no start is forgotten
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          prevReg[i]    <= IDLE[i];
          causeFlagN[i] <= 1'b1;
        end else begin
          prevReg[i] <= srcLevel[i];
          if (edgePulse[i]) begin
            causeFlagN[i] <= 1'b0;
          end else if (stopCmd) begin
            causeFlagN[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule // start_cause_latch

// ===== hw/dsp_condition_bit_map.v
/*
  Condition-bit interface of the embedded DSP: builds the 64-bit condition
  vector, resolves conditional jumps, keeps the 16 program-driven output
  bits, latches start causes, and offers an AXI4-Lite register port with a
  sticky interrupt on start causes.
  Assumes the sequencer, ALU and front ends sit on clk; only the start pin
  and the GPIO start pin are asynchronous.
*/
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
// Functional notes
// - a 64-bit condition vector gathers ALU, start causes, configuration and pins
// - conditional jump tests one selected bit and jumps only when it is 1
// - sixteen output bits are set and cleared one by one by instructions
// - condition bits 56 to 63 mirror output bits 0 to 7
// - bit 55 drops on pin falling edge or serial opcode start; stop restores
// - bit 53 drops when a GPIO pin started the DSP
// - bit 52 drops on converter overflow start; stop restores it
// - bit 51 drops when a rising edge of the interrupt output started the DSP
// - bit 50 drops on resistance-done start if enabled; stop restores it
// - bit 49 drops when internal timer expiry started the DSP
// - bit 48 marks end of capacitance conversion as the start cause
// - bits 42 to 47 carry both polarities of overflow, carry and equal; bit 41 marks a positive result
// - bit 25 is set while the internal timer still counts
// - bit 18 reads 0 for measure mode 2 and 1 for mode 1
// - a rising edge of any enabled start source (falling for the start pin) starts the DSP; cause held until stop
// - measurement-start output bits are one-cycle pulses that clear themselves

`timescale 1ns/1ps
`include "cond_bits_consts.vh"

module dsp_condition_bit_map #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              nrst,
  // sequencer: conditional jump
  input  wire              jumpValid,
  input  wire [5:0]        jumpSel,
  output reg               jumpDone,
  output reg               jumpTaken,
  // sequencer: bit set / bit clear / stop
  input  wire              bitSetInstr,
  input  wire              bit_clear_instr,
  input  wire [3:0]        bitIndex,
  input  wire              stopInstr,
  // ALU flags of the operation just completed
  input  wire              alu_overflow,
  input  wire              alu_carry,
  input  wire              alu_equal,
  input  wire              aluSign,
  // start sources on clk
  input  wire              capDone,
  input  wire              timerExpired,
  input  wire              resDone,
  input  wire              interrupt_out_pin_n,
  input  wire              time_converter_overflow,
  input  wire              serialStartCmd,
  // start sources from pins (asynchronous)
  input  wire              startPinN,
  input  wire              gpioStartPin,
  // timer status
  input  wire              timer_running,
  // program-driven outputs and start request
  output reg  [15:0]       outBits,
  output reg               dspStart,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  // AXI4-Lite write data
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  // AXI4-Lite write response
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  // AXI4-Lite read data
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // interrupt
  output reg               irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg  [`CFG_WIDTH-1:0]  config_reg;
  reg  [`NUM_CAUSES-1:0] irqStatus_reg;
  reg  [`NUM_CAUSES-1:0] irqMask_reg;
  reg  [ADDR_W-1:0]      wrAddr_reg;
  reg  [31:0]            wrData_reg;
  reg  [3:0]             wrStrb_reg;
  reg  [15:0]            outBits_next;
  reg  [31:0]            rdData_next;
  reg  [1:0]             rdResp_next;
  reg  [`NUM_CAUSES-1:0] irqStatus_next;
  reg                    irqLevel_next;
  wire [1:0]             pinSync;
  wire [`NUM_CAUSES-1:0] causeSrc;
  wire [`NUM_CAUSES-1:0] causeEnable;
  wire [`NUM_CAUSES-1:0] causeFlagN;
  wire [`NUM_CAUSES-1:0] causeEdge;
  wire [63:0]            condVec;
  wire                   wrFire;
  wire                   wrOk;
  wire                   wrIrqStatus;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  // both start pins pass two flops before any edge detector sees them
  sync2 #(
    .WIDTH   (2)
  ) uPinSync (
    .clk     (clk),
    .nrst    (nrst),
    .asyncIn ({gpioStartPin, ~startPinN}),
    .syncOut (pinSync)
  );

  // ---------------------------------------------------------------
  // start causes
  // ---------------------------------------------------------------
  // rising-edge view of each source; the start pin is inverted above so
  // its falling edge counts, and the serial opcode shares its channel
  assign causeSrc[`CH_CAP_DONE] = capDone;
  assign causeSrc[`CH_TIMER]    = timerExpired;
  assign causeSrc[`CH_RES_DONE] = resDone;
  assign causeSrc[`CH_IRQ_EDGE] = interrupt_out_pin_n;
  assign causeSrc[`CH_CONV_OVF] = time_converter_overflow;
  assign causeSrc[`CH_GPIO]     = pinSync[1];
  assign causeSrc[`CH_SERIAL]   = pinSync[0] | serialStartCmd;

  // resistance completion only counts with start-on-temperature enabled
  assign causeEnable = {{(`NUM_CAUSES-3){1'b1}},
                        config_reg[`CFG_START_ON_TEMP], 2'b11};

  start_cause_latch #(
    .WIDTH      (`NUM_CAUSES),
    .IDLE       (7'h01 << `CH_IRQ_EDGE) // interrupt line idles high
  ) uCauses (
    .clk        (clk),
    .nrst       (nrst),
    .srcLevel   (causeSrc),
    .chanEnable (causeEnable),
    .stopCmd    (stopInstr),
    .causeFlagN (causeFlagN),
    .edgePulse  (causeEdge)
  );

  // one start request per cycle with at least one accepted edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dspStart <= 1'b0;
    end else begin
      dspStart <= |causeEdge;
    end
  end

  // ---------------------------------------------------------------
  // condition vector
  // ---------------------------------------------------------------
  // built from live signals so the jump sees the ALU result of the
  // instruction just before it; unassigned positions are tied low
  assign condVec[63:`CV_OUT_LSB]     = outBits[7:0];
  assign condVec[`CV_SERIAL_N]       = causeFlagN[`CH_SERIAL];
  assign condVec[54]                 = 1'b0;
  assign condVec[`CV_GPIO_N]         = causeFlagN[`CH_GPIO];
  assign condVec[`CV_CONV_OVF_N]     = causeFlagN[`CH_CONV_OVF];
  assign condVec[`CV_IRQ_EDGE_N]     = causeFlagN[`CH_IRQ_EDGE];
  assign condVec[`CV_RES_DONE_N]     = causeFlagN[`CH_RES_DONE];
  assign condVec[`CV_TIMER_N]        = causeFlagN[`CH_TIMER];
  assign condVec[`CV_CAP_DONE_N]     = causeFlagN[`CH_CAP_DONE];
  assign condVec[`CV_NO_OVERFLOW]    = ~alu_overflow;
  assign condVec[`CV_OVERFLOW]       = alu_overflow;
  assign condVec[`CV_NO_CARRY]       = ~alu_carry;
  assign condVec[`CV_CARRY]          = alu_carry;
  assign condVec[`CV_EQUAL]          = alu_equal;
  assign condVec[`CV_NOT_EQUAL]      = ~alu_equal;
  assign condVec[`CV_POSITIVE]       = ~aluSign;
  assign condVec[40:26]              = 15'h0000;
  assign condVec[`CV_TIMER_RUN]      = timer_running;
  assign condVec[24:20]              = 5'h00;
  assign condVec[`CV_DUMMY_DCHG]     = config_reg[`CFG_DUMMY_DCHG];
  assign condVec[`CV_MODE_SEL_N]     = config_reg[`CFG_MODE_SEL_N];
  assign condVec[`CV_COMP_FORCE_N]   = config_reg[`CFG_COMP_FORCE_N];
  assign condVec[16:0]               = 17'h00000;

  // ---------------------------------------------------------------
  // conditional jump
  // ---------------------------------------------------------------
  // answer is registered; the bit itself is sampled in the request cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      jumpDone  <= 1'b0;
      jumpTaken <= 1'b0;
    end else begin
      jumpDone  <= jumpValid;
      jumpTaken <= jumpValid & condVec[jumpSel];
    end
  end

  // ---------------------------------------------------------------
  // program-driven output bits
  // ---------------------------------------------------------------
  // pulse bits drop after one cycle; set wins if both come together
  always @* begin
    outBits_next = outBits & ~`OUT_PULSE_MASK;
    if (bitSetInstr) begin
      outBits_next[bitIndex] = 1'b1;
    end else if (bit_clear_instr) begin
      outBits_next[bitIndex] = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outBits <= `OUT_RESET;
    end else begin
      outBits <= outBits_next;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  // address and data are captured independently; the write happens once
  // both are held, so the response never overtakes either channel
  assign wrFire = ~awready & ~wready & ~bvalid;
  assign wrOk   = (wrAddr_reg[7:0] == `OFS_CONFIG) ||
                  (wrAddr_reg[7:0] == `OFS_IRQ_STATUS) ||
                  (wrAddr_reg[7:0] == `OFS_IRQ_MASK) ||
                  (wrAddr_reg[7:0] == `OFS_COND_LOW) ||
                  (wrAddr_reg[7:0] == `OFS_COND_HIGH) ||
                  (wrAddr_reg[7:0] == `OFS_OUT_BITS);
  assign wrIrqStatus = wrFire && wrStrb_reg[0] &&
                       (wrAddr_reg[7:0] == `OFS_IRQ_STATUS);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      wrAddr_reg <= {ADDR_W{1'b0}};
      wrData_reg <= 32'h00000000;
      wrStrb_reg <= 4'h0;
    end else begin
      if (awready && awvalid) begin
        awready    <= 1'b0;
        wrAddr_reg <= awaddr;
      end
      if (wready && wvalid) begin
        wready     <= 1'b0;
        wrData_reg <= wdata;
        wrStrb_reg <= wstrb;
      end
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // configuration and mask registers; only byte lane 0 carries fields
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      config_reg  <= `CFG_RESET;
      irqMask_reg <= {`NUM_CAUSES{1'b0}};
    end else if (wrFire && wrStrb_reg[0]) begin
      if (wrAddr_reg[7:0] == `OFS_CONFIG) begin
        config_reg <= wrData_reg[`CFG_WIDTH-1:0];
      end else if (wrAddr_reg[7:0] == `OFS_IRQ_MASK) begin
        irqMask_reg <= wrData_reg[`NUM_CAUSES-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  // write-one-to-clear; a new cause in the clearing cycle stays set
  always @* begin
    irqStatus_next = irqStatus_reg;
    if (wrIrqStatus) begin
      irqStatus_next = irqStatus_next & ~wrData_reg[`NUM_CAUSES-1:0];
    end
    irqStatus_next = irqStatus_next | causeEdge;
    irqLevel_next  = |(irqStatus_next & irqMask_reg);
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus_reg <= {`NUM_CAUSES{1'b0}};
      irq           <= 1'b0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irq           <= irqLevel_next;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  // unmapped addresses answer zero with an error response
  always @* begin
    rdData_next = 32'h00000000;
    rdResp_next = `RESP_OKAY;
    if (araddr[7:0] == `OFS_CONFIG) begin
      rdData_next[`CFG_WIDTH-1:0] = config_reg;
    end else if (araddr[7:0] == `OFS_IRQ_STATUS) begin
      rdData_next[`NUM_CAUSES-1:0] = irqStatus_reg;
    end else if (araddr[7:0] == `OFS_IRQ_MASK) begin
      rdData_next[`NUM_CAUSES-1:0] = irqMask_reg;
    end else if (araddr[7:0] == `OFS_COND_LOW) begin
      rdData_next = condVec[31:0];
    end else if (araddr[7:0] == `OFS_COND_HIGH) begin
      rdData_next = condVec[63:32];
    end else if (araddr[7:0] == `OFS_OUT_BITS) begin
      rdData_next[15:0] = outBits;
    end else begin
      rdResp_next = `RESP_SLVERR;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arready && arvalid) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rdData_next;
        rresp   <= rdResp_next;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // dsp_condition_bit_map

// ===== verif/cond_bits_checker_properties.sv
/*
  Port checker of the condition-bit block, bound below.
  Assumes one clock clk and the async low reset nrst.
*/
`timescale 1ns/1ps

module cond_bits_checker (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // sequencer side
  input wire        jumpValid,
  input wire [5:0]  jumpSel,
  input wire        jumpDone,
  input wire        jumpTaken,
  input wire        bitSetInstr,
  input wire [3:0]  bitIndex,
  input wire        alu_equal,
  input wire        timer_running,
  input wire [15:0] outBits,
  // start side
  input wire        capDone,
  input wire        dspStart
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_done; jumpValid |=> jumpDone; endproperty
  a_done: assert property (p_done) else $error("jump not answered");
  property p_idle; !jumpValid |=> !jumpDone && !jumpTaken; endproperty
  a_idle: assert property (p_idle) else $error("answer without jump");
  property p_eq; jumpValid && jumpSel == 6'h2B |=> jumpTaken == $past(alu_equal); endproperty
  a_eq: assert property (p_eq) else $error("equal jump wrong");
  property p_ne; jumpValid && jumpSel == 6'h2A |=> jumpTaken != $past(alu_equal); endproperty
  a_ne: assert property (p_ne) else $error("not-equal jump wrong");
  property p_void; jumpValid && jumpSel < 6'h11 |=> !jumpTaken; endproperty
  a_void: assert property (p_void) else $error("unassigned bit jumped");
  property p_tmr; jumpValid && jumpSel == 6'h19 |=> jumpTaken == $past(timer_running);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer bit wrong");
  property p_mirror;
    jumpValid && jumpSel[5:3] == 3'h7 |=> jumpTaken == $past(outBits[jumpSel[2:0]]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("output mirror wrong");
  property p_set; bitSetInstr |=> outBits[$past(bitIndex)]; endproperty
  a_set: assert property (p_set) else $error("bit set lost");
  property p_pulse; !(bitSetInstr && bitIndex == 4'h8) |=> !outBits[8]; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse bit stuck");
  property p_start; $rose(capDone) |=> dspStart ##1 !dspStart; endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");

  // main scenarios seen
  c_jump: cover property (jumpValid && jumpSel == 6'h2B ##1 jumpTaken);
  c_start: cover property ($rose(capDone));
  c_pulse: cover property (outBits[8]);
endmodule // cond_bits_checker

bind dsp_condition_bit_map cond_bits_checker i_cond_bits_checker (
  .clk, .nrst, .jumpValid, .jumpSel, .jumpDone, .jumpTaken, .bitSetInstr,
  .bitIndex, .alu_equal, .timer_running, .outBits, .capDone, .dspStart);

// ===== verif/front_end_model.sv
/*
  Front-end model: each fire bit becomes a one-cycle done level,
  the way a unit reports completion. Assumes fire is one cycle long.
*/
`timescale 1ns/1ps

module front_end_model (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // requests in, done levels out
  input  wire [6:0] fire,
  output reg  [6:0] srcLevel
);
  // registered so the block sees a clean edge on clk
  always @(posedge clk or negedge nrst) begin
    if (!nrst) srcLevel <= 7'h00;
    else       srcLevel <= fire;
  end
endmodule // front_end_model

// ===== verif/dsp_condition_bit_map_tb.sv
/*
  Self-checking bench of the condition-bit block.
  Assumes the front-end model drives every start source except the start pin.
*/
`timescale 1ns/1ps
`include "cond_bits_consts.vh"

module dsp_condition_bit_map_tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  reg         clk = 1'b0, nrst = 1'b0, jumpValid = 1'b0, bitSet = 1'b0, bitClr = 1'b0;
  reg         stopInstr = 1'b0, timerRun = 1'b0, startPinN = 1'b1;
  reg  [5:0]  jumpSel = 6'h00;
  reg  [3:0]  bitIndex = 4'h0, alu = 4'h0; // alu: overflow carry equal sign
  reg  [6:0]  fire = 7'h00;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0, rv;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [1:0]  rr;
  wire        awready, wready, bvalid, arready, rvalid, jumpDone, jumpTaken, dspStart, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] outBits;
  wire [6:0]  src;
  integer     failures = 0, cmp_count = 0;

  always #12.5 clk = ~clk;

  front_end_model i_front_end_model (.clk(clk), .nrst(nrst), .fire(fire), .srcLevel(src));
  dsp_condition_bit_map i_dsp_condition_bit_map (.clk(clk), .nrst(nrst),
    .jumpValid(jumpValid), .jumpSel(jumpSel), .jumpDone(jumpDone), .jumpTaken(jumpTaken),
    .bitSetInstr(bitSet), .bit_clear_instr(bitClr), .bitIndex(bitIndex),
    .stopInstr(stopInstr), .alu_overflow(alu[3]), .alu_carry(alu[2]), .alu_equal(alu[1]),
    .aluSign(alu[0]), .capDone(src[0]), .timerExpired(src[1]), .resDone(src[2]),
    .interrupt_out_pin_n(src[3]), .time_converter_overflow(src[4]),
    .serialStartCmd(src[6]), .startPinN(startPinN), .gpioStartPin(src[5]),
    .timer_running(timerRun), .outBits(outBits), .dspStart(dspStart),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // write: both channels offered together, bready held until bvalid
  task wr(input [7:0] a, input [31:0] d);
    reg dn;
    begin
      dn = 1'b0;
      @(posedge clk); awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!dn) begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin dn = 1'b1; bready <= 1'b0; rr = bresp; end
      end
    end
  endtask

  task rd(input [7:0] a);
    reg dn;
    begin
      dn = 1'b0;
      @(posedge clk); araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!dn) begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin dn = 1'b1; rready <= 1'b0; rv = rdata; rr = rresp; end
      end
    end
  endtask

  // answer is checked 1 ns after the evaluating edge
  task jmp(input [5:0] s, input e);
    begin
      @(posedge clk); jumpValid <= 1'b1; jumpSel <= s;
      @(posedge clk); jumpValid <= 1'b0;
      #1 chk(jumpTaken, e);
    end
  endtask

  task bit_op(input s, input c, input [3:0] i);
    begin
      @(posedge clk); bitSet <= s; bitClr <= c; bitIndex <= i; stopInstr <= !s && !c;
      @(posedge clk); bitSet <= 1'b0; bitClr <= 1'b0; stopInstr <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      rd(`OFS_CONFIG); chk(rv, 32'h1);
      rd(`OFS_IRQ_MASK); chk(rv, 32'h0);
      rd(`OFS_COND_LOW); chk(rv, 32'h00040000);
      rd(`OFS_COND_HIGH); chk(rv, 32'h00BFA600);
      rd(8'h20); chk(rr, `RESP_SLVERR);
      wr(8'h20, 32'h0); chk(rr, `RESP_SLVERR);
      jmp(6'h05, 1'b0); jmp(6'h36, 1'b0);
      $display("t_reset done");
    end
  endtask

  // every flag combination, both polarities, timer busy alongside
  task t_alu;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        @(posedge clk); alu <= k[3:0]; timerRun <= k[0];
        jmp(6'h2F, !k[3]); jmp(6'h2E, k[3]); jmp(6'h2D, !k[2]);
        jmp(6'h2C, k[2]); jmp(6'h2B, k[1]); jmp(6'h2A, !k[1]);
        jmp(6'h29, !k[0]); jmp(6'h19, k[0]);
      end
      $display("t_alu done");
    end
  endtask

  task t_bits;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bit_op(1'b1, 1'b0, i[3:0]); jmp(6'h38 + i[5:0], 1'b1);
        bit_op(1'b0, 1'b1, i[3:0]); jmp(6'h38 + i[5:0], 1'b0);
      end
      bit_op(1'b1, 1'b0, 4'h3); bit_op(1'b1, 1'b0, 4'h5); bit_op(1'b1, 1'b0, 4'h8);
      #1 chk(outBits, 16'h0128);
      @(posedge clk); #1 chk(outBits, 16'h0028);
      rd(`OFS_OUT_BITS); chk(rv, 32'h28);
      bit_op(1'b0, 1'b1, 4'h3); bit_op(1'b0, 1'b1, 4'h5);
      $display("t_bits done");
    end
  endtask

  // per cause: flag drops, irq masked then raised, W1C, held until stop
  task t_cause;
    integer c; reg [5:0] fb;
    begin
      wr(`OFS_CONFIG, 32'h3); chk(rr, `RESP_OKAY);
      for (c = 0; c < 7; c = c + 1) begin
        fb = (c == 6) ? 6'h37 : 6'h30 + c[5:0];
        wr(`OFS_IRQ_MASK, 32'h7F ^ (32'h1 << c));
        @(posedge clk); fire <= 7'h01 << c;
        @(posedge clk); fire <= 7'h00;
        repeat (6) @(posedge clk);
        jmp(fb, 1'b0);
        chk(irq, 1'b0);
        wr(`OFS_IRQ_MASK, 32'h7F); @(posedge clk); #1 chk(irq, 1'b1);
        rd(`OFS_IRQ_STATUS); chk(rv, 32'h1 << c);
        wr(`OFS_IRQ_STATUS, 32'h1 << c); @(posedge clk); #1 chk(irq, 1'b0);
        jmp(fb, 1'b0);
        bit_op(1'b0, 1'b0, 4'h0); jmp(fb, 1'b1);
      end
      wr(`OFS_CONFIG, 32'h0);
      @(posedge clk); fire <= 7'h04;
      @(posedge clk); fire <= 7'h00;
      rd(`OFS_IRQ_STATUS); chk(rv, 32'h0);
      jmp(6'h32, 1'b1);
      jmp(6'h12, 1'b0);
      @(posedge clk); startPinN <= 1'b0;
      repeat (6) @(posedge clk);
      jmp(6'h37, 1'b0);
      bit_op(1'b0, 1'b0, 4'h0); startPinN <= 1'b1;
      jmp(6'h37, 1'b1);
      $display("t_cause done");
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset; t_alu; t_bits; t_cause;
    test_done;
  end

  // watchdog: the run needs well under 4000 cycles
  initial begin
    #100000;
    failures = failures + 1;
    test_done;
  end
endmodule // dsp_condition_bit_map_tb
